// File: can_rx_mask_regs.svh
// Purpose: Register offsets, field positions and reset values of the receive mask block.
// Assumes: Registers are 16 bits wide and addressed by a 4-bit word index.
// Notes:   Definitions only; included by the design and the testbench.
`ifndef CAN_RX_MASK_REGS_SVH
`define CAN_RX_MASK_REGS_SVH

// ---------------------------------------------------------------------------
// Register word indices.
// ---------------------------------------------------------------------------
`define ADDR_MASK_SOURCE   4'h0
`define ADDR_STD_MASK0     4'h1
`define ADDR_STD_MASK1     4'h2
`define ADDR_STD_MASK2     4'h3
`define ADDR_EXT_MASK0     4'h4
`define ADDR_EXT_MASK1     4'h5
`define ADDR_EXT_MASK2     4'h6
`define ADDR_FULL_LOW      4'h7
`define ADDR_FULL_HIGH     4'h8
`define ADDR_OVF_LOW       4'h9
`define ADDR_OVF_HIGH      4'ha
`define ADDR_INT_STATUS    4'hb
`define ADDR_INT_MASK      4'hc

// ---------------------------------------------------------------------------
// Field positions and values.
// ---------------------------------------------------------------------------
`define STD_SID_HI         15
`define STD_SID_LO         5
`define STD_TYPE_MATCH     3
`define STD_IMPL_BITS      16'hffeb
`define MASK_SRC_RESERVED  2'h3
`define INT_STORE_BIT      0
`define INT_OVF_BIT        1

// ---------------------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------------------
`define MASK_SOURCE_RST    16'h0000
`define FLAGS_RST          32'h0000_0000
`define INT_RST            2'h0
`define RDATA_RST          16'h0000

`endif

// File: can_rx_mask_pkg.sv
// Purpose: Types shared by the receive mask and buffer status block.
// Assumes: Filter index 0 to 7 stands for filters 8 to 15.
// Notes:   Constants live in the register header.
package can_rx_mask_pkg;

  // Fields of a received message that take part in acceptance.
  typedef struct packed {
    logic [10:0] standard_identifier_bits;  // Standard identifier.
    logic [17:0] extended_identifier_bits;  // Extended identifier.
    logic        is_extended;               // Frame carries an extended identifier.
  } msg_id_t;

  // One candidate comparison presented by the protocol engine.
  typedef struct packed {
    logic [2:0]  filter_index;              // Filter number minus eight.
    logic [10:0] standard_identifier_bits;  // Filter value, standard part.
    logic [17:0] extended_identifier_bits;  // Filter value, extended part.
    logic        filter_extended_select;    // Filter targets extended frames.
    logic [4:0]  dest_buffer;               // Buffer written on a hit.
  } filter_cand_t;

endpackage

// File: can_rx_mask_status.sv
// Purpose: Mask selection for filters 8 to 15, acceptance masks and buffer flags.
// Assumes: The protocol engine presents one candidate per cycle with cand_valid.
// Notes:   A hit stores into the destination buffer in the same cycle.
`timescale 1ns/1ps
`include "can_rx_mask_regs.svh"

module can_rx_mask_status
  import can_rx_mask_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [3:0]   addr,
  input  wire logic [15:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [15:0]  rdata,
  input  wire logic         cand_valid,
  input  wire filter_cand_t cand,
  input  wire msg_id_t      msg,
  output logic              hit_valid,
  output logic              hit,
  output logic              irq
);

  // ---------------------------------------------------------------------------
  // Helper functions.
  // ---------------------------------------------------------------------------

  // Acceptance of one message against one filter under one mask.
  function automatic logic filter_match(input msg_id_t m, input filter_cand_t f,
                                        input logic [15:0] sm, input logic [15:0] em);
    logic        sid_ok;
    logic        eid_ok;
    logic [17:0] eid_mask;
    sid_ok   = ((m.standard_identifier_bits ^ f.standard_identifier_bits)
                & sm[`STD_SID_HI:`STD_SID_LO]) == 11'h000;
    eid_mask = {sm[1:0], em};
    eid_ok   = ((m.extended_identifier_bits ^ f.extended_identifier_bits)
                & eid_mask) == 18'h00000;
    if (sm[`STD_TYPE_MATCH]) begin
      // Format must agree with the filter's extended select.
      filter_match = (m.is_extended == f.filter_extended_select)
                     && sid_ok && (!m.is_extended || eid_ok);
    end else begin
      // Either format; a standard frame compares only its standard part.
      filter_match = sid_ok && (!m.is_extended || eid_ok);
    end
  endfunction

  // One-hot decode of a buffer number, used for full and overflow sets.
  function automatic logic [31:0] buf_onehot(input logic [4:0] b);
    buf_onehot = 32'h0000_0001 << b;
  endfunction

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  logic [15:0] mask_source_reg;     // Mask source fields, filters 15 down to 8.
  logic [15:0] mask_source_next;    // Next mask source fields.
  logic [15:0] std_mask_reg [3];    // Standard mask registers, one per mask.
  logic [15:0] ext_mask_reg [3];    // Extended mask registers, one per mask.
  logic [31:0] full_reg;            // Buffer full flags.
  logic [31:0] full_next;           // Next full flags.
  logic [31:0] ovf_reg;             // Buffer overflow flags.
  logic [31:0] ovf_next;            // Next overflow flags.
  logic [1:0]  int_status_reg;      // Sticky event bits.
  logic [1:0]  int_status_next;     // Next sticky event bits.
  logic [1:0]  int_mask_reg;        // Interrupt enables.
  logic [1:0]  int_mask_next;       // Next interrupt enables.
  logic [15:0] rdata_reg;           // Read data register.
  logic [15:0] rdata_next;          // Next read data.
  logic        hit_valid_reg;       // Candidate evaluated last cycle.
  logic        hit_reg;             // Result of that evaluation.
  logic        irq_reg;             // Interrupt level.
  logic        irq_next;            // Next interrupt level.

  // ---------------------------------------------------------------------------
  // Acceptance.
  // ---------------------------------------------------------------------------
  logic [1:0]  sel_src;             // Mask source of the current candidate.
  logic [15:0] sel_std;             // Selected standard mask.
  logic [15:0] sel_ext;             // Selected extended mask.
  logic        hit_now;             // Candidate accepted this cycle.
  logic [31:0] store_set;           // Buffers being stored this cycle.
  logic [31:0] ovf_set;             // Buffers overflowing this cycle.

  // Pick the mask named by the filter's source field; reserved never hits.
  always_comb begin
    sel_src = mask_source_reg[{cand.filter_index, 1'b0} +: 2];
    sel_std = 16'h0000;
    sel_ext = 16'h0000;
    case (sel_src)
      2'h0: begin
        sel_std = std_mask_reg[0];
        sel_ext = ext_mask_reg[0];
      end
      2'h1: begin
        sel_std = std_mask_reg[1];
        sel_ext = ext_mask_reg[1];
      end
      2'h2: begin
        sel_std = std_mask_reg[2];
        sel_ext = ext_mask_reg[2];
      end
      default: begin
        sel_std = 16'h0000;
      end
    endcase
    // A reserved source is treated as no mask at all, so nothing is accepted.
    hit_now = cand_valid && (sel_src != `MASK_SRC_RESERVED)
              && filter_match(msg, cand, sel_std, sel_ext);
  end

  // Per-buffer store and overflow events. The decode sits in a net of its own
  // because a bit cannot be selected straight out of a function result.
  logic [31:0] dest_onehot;         // Destination buffer, one-hot.
  assign dest_onehot = buf_onehot(cand.dest_buffer);
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_buf
      assign store_set[gi] = hit_now && dest_onehot[gi];
      assign ovf_set[gi]   = store_set[gi] && full_reg[gi];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Register next values.
  // ---------------------------------------------------------------------------

  // Bus writes, flag updates and read data. Sets are ORed in last so that a
  // clear landing on the same cycle as a store never loses the event.
  always_comb begin
    mask_source_next = mask_source_reg;
    full_next        = full_reg;
    ovf_next         = ovf_reg;
    int_status_next  = int_status_reg;
    int_mask_next    = int_mask_reg;
    rdata_next       = `RDATA_RST;
    if (wr) begin
      case (addr)
        `ADDR_MASK_SOURCE: mask_source_next = wdata;
        `ADDR_FULL_LOW:    full_next[15:0]  = full_reg[15:0] & wdata;
        `ADDR_FULL_HIGH:   full_next[31:16] = full_reg[31:16] & wdata;
        `ADDR_OVF_LOW:     ovf_next[15:0]   = ovf_reg[15:0] & wdata;
        `ADDR_OVF_HIGH:    ovf_next[31:16]  = ovf_reg[31:16] & wdata;
        `ADDR_INT_STATUS:  int_status_next  = int_status_reg & ~wdata[1:0];
        `ADDR_INT_MASK:    int_mask_next    = wdata[1:0];
        default: begin
          full_next = full_next;
        end
      endcase
    end
    full_next = full_next | store_set;
    ovf_next  = ovf_next | ovf_set;
    int_status_next[`INT_STORE_BIT] = int_status_next[`INT_STORE_BIT] | hit_now;
    int_status_next[`INT_OVF_BIT]   = int_status_next[`INT_OVF_BIT] | (|ovf_set);
    irq_next = |(int_status_next & int_mask_next);
    if (rd) begin
      case (addr)
        `ADDR_MASK_SOURCE: rdata_next = mask_source_reg;
        `ADDR_STD_MASK0:   rdata_next = std_mask_reg[0] & `STD_IMPL_BITS;
        `ADDR_STD_MASK1:   rdata_next = std_mask_reg[1] & `STD_IMPL_BITS;
        `ADDR_STD_MASK2:   rdata_next = std_mask_reg[2] & `STD_IMPL_BITS;
        `ADDR_EXT_MASK0:   rdata_next = ext_mask_reg[0];
        `ADDR_EXT_MASK1:   rdata_next = ext_mask_reg[1];
        `ADDR_EXT_MASK2:   rdata_next = ext_mask_reg[2];
        `ADDR_FULL_LOW:    rdata_next = full_reg[15:0];
        `ADDR_FULL_HIGH:   rdata_next = full_reg[31:16];
        `ADDR_OVF_LOW:     rdata_next = ovf_reg[15:0];
        `ADDR_OVF_HIGH:    rdata_next = ovf_reg[31:16];
        `ADDR_INT_STATUS:  rdata_next = {14'h0000, int_status_reg};
        `ADDR_INT_MASK:    rdata_next = {14'h0000, int_mask_reg};
        default:           rdata_next = `RDATA_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------------

  // Control state with a defined reset value.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask_source_reg <= `MASK_SOURCE_RST;
      full_reg        <= `FLAGS_RST;
      ovf_reg         <= `FLAGS_RST;
      int_status_reg  <= `INT_RST;
      int_mask_reg    <= `INT_RST;
      rdata_reg       <= `RDATA_RST;
      hit_valid_reg   <= 1'b0;
      hit_reg         <= 1'b0;
      irq_reg         <= 1'b0;
    end else begin
      mask_source_reg <= mask_source_next;
      full_reg        <= full_next;
      ovf_reg         <= ovf_next;
      int_status_reg  <= int_status_next;
      int_mask_reg    <= int_mask_next;
      rdata_reg       <= rdata_next;
      hit_valid_reg   <= cand_valid;
      hit_reg         <= hit_now;
      irq_reg         <= irq_next;
    end
  end

  // Mask identifier bits have no reset; software must load them before use,
  // which saves reset wiring on 96 data flops.
  always_ff @(posedge clock) begin
    if (wr && addr >= `ADDR_STD_MASK0 && addr <= `ADDR_STD_MASK2) begin
      std_mask_reg[2'(addr - `ADDR_STD_MASK0)] <= wdata & `STD_IMPL_BITS;
    end
    if (wr && addr >= `ADDR_EXT_MASK0 && addr <= `ADDR_EXT_MASK2) begin
      ext_mask_reg[2'(addr - `ADDR_EXT_MASK0)] <= wdata;
    end
  end

  assign rdata     = rdata_reg;
  assign hit_valid = hit_valid_reg;
  assign hit       = hit_reg;
  assign irq       = irq_reg;

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------

  // A reserved source never accepts.
  rsv_src_nohit_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && sel_src == 2'h3 |=> hit_valid_reg && !hit_reg)
    else $error("reserved mask source accepted a message");

  // The source field of filter 15 is the top pair.
  src_top_pair_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && cand.filter_index == 3'h7 |-> sel_src == mask_source_reg[15:14])
    else $error("filter 15 source not taken from top pair");

  // All-zero standard mask accepts any standard frame.
  std_dontcare_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && sel_src != 2'h3 && sel_std == 16'h0000 && !msg.is_extended
    |=> hit_reg)
    else $error("don't-care standard mask rejected a frame");

  // Mismatch in an included extended bit rejects an extended frame.
  ext_compare_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && msg.is_extended
    && (((msg.extended_identifier_bits ^ cand.extended_identifier_bits)
         & {sel_std[1:0], sel_ext}) != 18'h00000) |=> !hit_reg)
    else $error("extended mismatch was accepted");

  // Type match on and format differs: rejected.
  type_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && sel_std[3] && msg.is_extended != cand.filter_extended_select
    |=> !hit_reg)
    else $error("format mismatch accepted under type match");

  // Type match off, masks open: either format accepted.
  either_format_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && sel_src != 2'h3 && sel_std == 16'h0000 && sel_ext == 16'h0000
    |=> hit_reg)
    else $error("open mask without type match rejected a frame");

  // Unimplemented mask bits read zero.
  std_rsv_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && addr >= 4'h1 && addr <= 4'h3 |=> rdata_reg[4] == 1'b0 && rdata_reg[2] == 1'b0)
    else $error("unimplemented mask bit read as one");

  // A hit sets the destination's full flag and raises an event.
  store_full_a: assert property (@(posedge clock) disable iff (!rst_n)
    hit_now |=> full_reg[$past(cand.dest_buffer)] && int_status_reg[0])
    else $error("stored buffer not flagged full");

  // Storing into a full buffer sets overflow.
  store_ovf_a: assert property (@(posedge clock) disable iff (!rst_n)
    hit_now && full_reg[cand.dest_buffer] |=> ovf_reg[$past(cand.dest_buffer)])
    else $error("overflow not flagged");

  // High full register reads buffers 16 to 31.
  full_high_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && addr == 4'h8 |=> rdata_reg == $past(full_reg[31:16]))
    else $error("high full register read wrong");

  // Writing ones leaves the low overflow flags as they were.
  ovf_w1_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && addr == 4'h9 && wdata == 16'hffff && !hit_now
    |=> ovf_reg[15:0] == $past(ovf_reg[15:0]))
    else $error("write of one changed an overflow flag");

  // After reset the sources and flags are zero.
  reset_zero_a: assert property (@(posedge clock)
    $rose(rst_n) |-> mask_source_reg == 16'h0000 && full_reg == 32'h0 && ovf_reg == 32'h0)
    else $error("flags not cleared by reset");

  // Writing ones leaves the low full flags as they were.
  full_w1_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
    wr && addr == 4'h7 && wdata == 16'hffff && !hit_now
    |=> full_reg[15:0] == $past(full_reg[15:0]))
    else $error("write of one changed a full flag");

  // A store landing on the cycle of a clear keeps its full flag.
  set_beats_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
    hit_now && wr && addr == 4'h7 && cand.dest_buffer < 5'd16
    |=> full_reg[$past(cand.dest_buffer)])
    else $error("clear won over a store");

  // Low overflow register reads buffers 0 to 15.
  ovf_low_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    rd && addr == 4'h9 |=> rdata_reg == $past(ovf_reg[15:0]))
    else $error("low overflow register read wrong");

  // Type match on, format agrees, identifiers equal: accepted.
  type_pass_a: assert property (@(posedge clock) disable iff (!rst_n)
    cand_valid && sel_src != 2'h3 && sel_std[3] && !msg.is_extended
    && !cand.filter_extended_select
    && msg.standard_identifier_bits == cand.standard_identifier_bits |=> hit_reg)
    else $error("matching format rejected under type match");

  // Read data stands only in the cycle after a read strobe.
  rdata_idle_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    !rd |=> rdata_reg == 16'h0000)
    else $error("read data not zero outside a read");

  // The interrupt level follows the status and mask registers.
  irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
    irq_reg == |(int_status_reg & int_mask_reg))
    else $error("interrupt level disagrees with status and mask");

  // Main scenarios.
  hit_seen_c: cover property (@(posedge clock) disable iff (!rst_n) hit_now);
  ovf_seen_c: cover property (@(posedge clock) disable iff (!rst_n) |ovf_set);
  irq_seen_c: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq_reg));
  clr_set_c:  cover property (@(posedge clock) disable iff (!rst_n)
    hit_now && wr && addr == 4'h7);

endmodule

// File: engine_model.sv
// Purpose: Behavioural protocol engine that offers acceptance candidates.
// Assumes: One candidate per call, held for exactly one clock.
// Notes:   Between candidates the fields flip, so stale values never pass for live ones.
`timescale 1ns/1ps

module engine_model
  import can_rx_mask_pkg::*;
(
  input  wire logic    clock,
  output logic         cand_valid,
  output filter_cand_t cand,
  output msg_id_t      msg
);

  // ---------------------------------------------------------------------------
  // Candidate driver
  // ---------------------------------------------------------------------------
  // Idle and known at time zero.
  initial begin
    cand_valid = 1'b0;
    cand       = '0;
    msg        = '0;
  end

  // Offers one candidate for one cycle, then inverts the fields it leaves behind.
  task automatic present(input filter_cand_t c, input msg_id_t m);
    @(posedge clock);
    cand_valid <= 1'b1;
    cand       <= c;
    msg        <= m;
    @(posedge clock);
    cand_valid <= 1'b0;
    cand       <= ~c;
    msg        <= ~m;
  endtask

endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the receive mask and buffer status block.
// Assumes: Register reads answer one cycle after the read strobe.
// Notes:   Standard mask registers are written before any candidate, they have no reset.
`timescale 1ns/1ps
`include "can_rx_mask_regs.svh"
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end

module testbench
  import can_rx_mask_pkg::*;
;
  logic         clock;       // Bus clock.
  logic         rst_n;       // Synchronous reset, active low.
  logic [3:0]   addr;        // Register word index.
  logic [15:0]  wdata;       // Write data.
  logic         wr;          // Write strobe.
  logic         rd;          // Read strobe.
  logic [15:0]  rdata;       // Read data.
  logic         cand_valid;  // Candidate present.
  filter_cand_t cand;        // Candidate filter.
  msg_id_t      msg;         // Received identifier.
  logic         hit_valid;   // Result present.
  logic         hit;         // Acceptance result.
  logic         irq;         // Interrupt level.
  int           n_mismatch;  // Mismatches seen.
  int           n_tests;     // Comparisons made.

  can_rx_mask_status u_can_rx_mask_status (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cand_valid(cand_valid), .cand(cand),
    .msg(msg), .hit_valid(hit_valid), .hit(hit), .irq(irq));
  engine_model u_engine_model (.clock(clock), .cand_valid(cand_valid), .cand(cand), .msg(msg));

  // ---------------------------------------------------------------------------
  // Clock, bus and candidate tasks
  // ---------------------------------------------------------------------------
  always #50 clock = ~clock;

  // Holds reset for eight edges; a second call also checks reset in mid-run.
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // One-cycle write strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the single cycle it stands.
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    `CHK("rdata", exp, rdata)
  endtask

  // Offers a candidate through the engine model and judges the result cycle.
  task automatic cand_chk(input logic [2:0] fi, input logic [10:0] fs, input logic [17:0] fe,
                          input logic fx, input logic [4:0] db, input logic [10:0] ms,
                          input logic [17:0] me, input logic mx, input logic exp);
    u_engine_model.present('{fi, fs, fe, fx, db}, '{ms, me, mx});
    #1;
    `CHK("hit_valid", 1'b1, hit_valid)
    `CHK("hit", exp, hit)
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Every resettable register reads zero; an unmapped index reads zero too.
  task automatic t_reset();
    rd_chk(`ADDR_MASK_SOURCE, 16'h0000);
    rd_chk(`ADDR_INT_STATUS, 16'h0000);
    rd_chk(`ADDR_INT_MASK, 16'h0000);
    rd_chk(`ADDR_FULL_LOW, 16'h0000);
    rd_chk(`ADDR_FULL_HIGH, 16'h0000);
    rd_chk(`ADDR_OVF_LOW, 16'h0000);
    rd_chk(`ADDR_OVF_HIGH, 16'h0000);
    rd_chk(4'he, 16'h0000);
  endtask

  // Field layout read-back and the two dead mask bits.
  task automatic t_regs();
    wr_reg(`ADDR_MASK_SOURCE, 16'h8001);
    rd_chk(`ADDR_MASK_SOURCE, 16'h8001);
    wr_reg(`ADDR_STD_MASK1, 16'hffff);
    rd_chk(`ADDR_STD_MASK1, 16'hffeb);
    wr_reg(`ADDR_EXT_MASK2, 16'ha5a5);
    rd_chk(`ADDR_EXT_MASK2, 16'ha5a5);
  endtask

  // Each source code on filter 15 and filter 8; only mask 1 ignores the identifier.
  task automatic t_select();
    wr_reg(`ADDR_STD_MASK0, 16'hffe0);
    wr_reg(`ADDR_STD_MASK1, 16'h0000);
    wr_reg(`ADDR_STD_MASK2, 16'hffe0);
    for (int c = 0; c < 4; c++) begin
      wr_reg(`ADDR_MASK_SOURCE, 16'(c) << 14);
      cand_chk(3'h7, 11'h123, '0, 1'b0, 5'h0, 11'h321, '0, 1'b0, c == 1);
      wr_reg(`ADDR_MASK_SOURCE, 16'(c));
      cand_chk(3'h0, 11'h123, '0, 1'b0, 5'h0, 11'h321, '0, 1'b0, c == 1);
    end
  endtask

  // Per-bit inclusion of standard and extended identifier bits through mask 0.
  task automatic t_compare();
    wr_reg(`ADDR_MASK_SOURCE, 16'h0000);
    wr_reg(`ADDR_EXT_MASK0, 16'h0000);
    cand_chk(3'h2, 11'h123, '0, 1'b0, 5'h0, 11'h123, '0, 1'b0, 1'b1);
    cand_chk(3'h2, 11'h123, '0, 1'b0, 5'h0, 11'h122, '0, 1'b0, 1'b0);
    wr_reg(`ADDR_STD_MASK0, 16'hffc0);
    cand_chk(3'h2, 11'h123, '0, 1'b0, 5'h0, 11'h122, '0, 1'b0, 1'b1);
    wr_reg(`ADDR_STD_MASK0, 16'hffe3);
    wr_reg(`ADDR_EXT_MASK0, 16'hffff);
    cand_chk(3'h2, 11'h5a, 18'h2abcd, 1'b1, 5'h0, 11'h5a, 18'h2abcd, 1'b1, 1'b1);
    cand_chk(3'h2, 11'h5a, 18'h2abcd, 1'b1, 5'h0, 11'h5a, 18'h0abcd, 1'b1, 1'b0);
    cand_chk(3'h2, 11'h5a, 18'h2abcd, 1'b1, 5'h0, 11'h5a, 18'h2abcc, 1'b1, 1'b0);
    wr_reg(`ADDR_EXT_MASK0, 16'hfffe);
    cand_chk(3'h2, 11'h5a, 18'h2abcd, 1'b1, 5'h0, 11'h5a, 18'h2abcc, 1'b1, 1'b1);
  endtask

  // Frame format match with the type-match bit set and clear.
  task automatic t_type();
    wr_reg(`ADDR_EXT_MASK0, 16'h0000);
    wr_reg(`ADDR_STD_MASK0, 16'hffe8);
    cand_chk(3'h3, 11'h77, '0, 1'b1, 5'h0, 11'h77, '0, 1'b0, 1'b0);
    cand_chk(3'h3, 11'h77, '0, 1'b0, 5'h0, 11'h77, '0, 1'b0, 1'b1);
    cand_chk(3'h3, 11'h77, '0, 1'b1, 5'h0, 11'h77, '1, 1'b1, 1'b1);
    wr_reg(`ADDR_STD_MASK0, 16'hffe0);
    cand_chk(3'h3, 11'h77, '0, 1'b1, 5'h0, 11'h77, '0, 1'b0, 1'b1);
    cand_chk(3'h3, 11'h77, '0, 1'b0, 5'h0, 11'h77, '1, 1'b1, 1'b1);
  endtask

  // Full and overflow flags, clear-only access and the interrupt.
  task automatic t_flags();
    @(posedge clock);
    do_reset();
    rd_chk(`ADDR_FULL_LOW, 16'h0000);
    wr_reg(`ADDR_INT_MASK, 16'h0001);
    cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd5, 11'h11, '0, 1'b0, 1'b0);
    rd_chk(`ADDR_FULL_LOW, 16'h0000);
    cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd3, 11'h10, '0, 1'b0, 1'b1);
    `CHK("irq", 1'b1, irq)
    cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd20, 11'h10, '0, 1'b0, 1'b1);
    rd_chk(`ADDR_FULL_LOW, 16'h0008);
    rd_chk(`ADDR_FULL_HIGH, 16'h0010);
    rd_chk(`ADDR_OVF_LOW, 16'h0000);
    cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd3, 11'h10, '0, 1'b0, 1'b1);
    cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd20, 11'h10, '0, 1'b0, 1'b1);
    rd_chk(`ADDR_OVF_LOW, 16'h0008);
    rd_chk(`ADDR_OVF_HIGH, 16'h0010);
    rd_chk(`ADDR_INT_STATUS, 16'h0003);
    wr_reg(`ADDR_FULL_LOW, 16'hffff);
    rd_chk(`ADDR_FULL_LOW, 16'h0008);
    wr_reg(`ADDR_FULL_LOW, 16'hfff7);
    rd_chk(`ADDR_FULL_LOW, 16'h0000);
    wr_reg(`ADDR_OVF_LOW, 16'hffff);
    rd_chk(`ADDR_OVF_LOW, 16'h0008);
    wr_reg(`ADDR_OVF_LOW, 16'hfff7);
    rd_chk(`ADDR_OVF_LOW, 16'h0000);
    rd_chk(`ADDR_OVF_HIGH, 16'h0010);
    // A clear of every low full flag on the very edge of a store into buffer 3.
    cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd3, 11'h10, '0, 1'b0, 1'b1);
    fork
      wr_reg(`ADDR_FULL_LOW, 16'h0000);
      cand_chk(3'h1, 11'h10, '0, 1'b0, 5'd3, 11'h10, '0, 1'b0, 1'b1);
    join
    rd_chk(`ADDR_FULL_LOW, 16'h0008);
    rd_chk(`ADDR_OVF_LOW, 16'h0008);
    wr_reg(`ADDR_INT_STATUS, 16'h0001);
    #1;
    `CHK("irq", 1'b0, irq)
    wr_reg(`ADDR_INT_MASK, 16'h0002);
    #1;
    `CHK("irq", 1'b1, irq)
    wr_reg(`ADDR_INT_STATUS, 16'h0002);
    #1;
    `CHK("irq", 1'b0, irq)
  endtask

  // ---------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------------------
  // The only place the run ends.
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The scenarios need well under a thousand cycles; five thousand means a hang.
  initial begin
    #(100 * 5000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    clock      = 1'b0;
    rst_n      = 1'b0;
    addr       = 4'h0;
    wdata      = 16'h0000;
    wr         = 1'b0;
    rd         = 1'b0;
    n_mismatch = 0;
    n_tests    = 0;
    do_reset();
    t_reset();
    t_regs();
    t_select();
    t_compare();
    t_type();
    t_flags();
    complete_run();
  end

endmodule
